/* File: design/tffd_core.sv */
/*
 * tilt position, flat and free-fall engines with their register port.
 * assumes samples come from filter logic on the same clock, one pulse
 * on sample_valid_in per sample, 1 g = 1024 lsb whatever the range.
 */
// Decided for this implementation: the strobed register port and the register addresses.
module tffd_core
   import tffd_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // register port
   input  wire tffd_bus_t   bus_in,
   output logic [31:0]      rd_data_out,
   // filtered samples
   input  wire logic        sample_valid_in,
   input  wire tffd_acc_t   acc_in,
   // engine state
   output logic [2:0]       position_code_out,
   output logic             flat_state_out,
   output logic             freefall_state_out,
   output logic             position_event_out,
   output logic             flat_event_out
);

   ////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [15:0] abs16(input logic signed [15:0] v);
      abs16 = v[15] ? 16'(-v) : 16'(v);
   endfunction

   // clamp to 1 g so the blocking angles hold at rest
   function automatic logic [10:0] sat1g(input logic [15:0] m);
      sat1g = (m > ACC_1G) ? 11'(ACC_1G) : 11'(m);
   endfunction

   function automatic logic [16:0] dabs(input logic signed [15:0] a,
                                        input logic signed [15:0] b);
      logic signed [16:0] d;
      d = 17'(a) - 17'(b);
      dabs = d[16] ? 17'(-d) : 17'(d);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]  ctrl_ff;
   logic [5:0]  block_ang_ff;
   logic [5:0]  flat_ang_ff;
   logic [2:0]  level_hysteresis_ff;
   logic [1:0]  hold_sel_ff;
   logic [7:0]  freefall_threshold_ff;
   logic [7:0]  ff_dur_ff;
   logic [1:0]  freefall_hysteresis_ff;
   logic [31:0] rd_data_ff;

   logic        pos_evt_ff;
   logic        flat_evt_ff;
   logic [2:0]  code_ff;
   logic        flat_ff;
   logic        ff_state_ff;

   logic        wr_status;
   logic        clr_pos;
   logic        clr_flat;

   assign wr_status = bus_in.wr && (bus_in.addr == OFS_STATUS);
   assign clr_pos   = wr_status && bus_in.wdata[ST_POS_EVT];
   assign clr_flat  = wr_status && bus_in.wdata[ST_FLAT_EVT];

   // configuration writes
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_ff                <= RST_CTRL;
         block_ang_ff           <= RST_BLOCK_ANG;
         flat_ang_ff            <= RST_FLAT_ANG;
         level_hysteresis_ff    <= '0;
         hold_sel_ff            <= '0;
         freefall_threshold_ff  <= RST_FF_THR;
         ff_dur_ff              <= RST_FF_DUR;
         freefall_hysteresis_ff <= '0;
      end else if (bus_in.wr) begin
         if (bus_in.addr == OFS_CTRL) begin
            ctrl_ff <= bus_in.wdata[7:0];
         end else if (bus_in.addr == OFS_ANGLE) begin
            block_ang_ff        <= bus_in.wdata[ANG_BLOCK_LO +: 6];
            flat_ang_ff         <= bus_in.wdata[ANG_FLAT_LO +: 6];
            level_hysteresis_ff <= bus_in.wdata[ANG_HYST_LO +: 3];
            hold_sel_ff         <= bus_in.wdata[ANG_HOLD_LO +: 2];
         end else if (bus_in.addr == OFS_FREEFALL) begin
            freefall_threshold_ff  <= bus_in.wdata[FF_THR_LO +: 8];
            ff_dur_ff              <= bus_in.wdata[FF_DUR_LO +: 8];
            freefall_hysteresis_ff <= bus_in.wdata[FF_HYST_LO +: 2];
         end
      end
   end

   // read data, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_ff <= '0;
      end else if (bus_in.rd) begin
         if (bus_in.addr == OFS_CTRL) begin
            rd_data_ff <= {24'h00_0000, ctrl_ff};
         end else if (bus_in.addr == OFS_ANGLE) begin
            rd_data_ff <= {10'h000, hold_sel_ff, 1'b0, level_hysteresis_ff,
                           2'b00, flat_ang_ff, 2'b00, block_ang_ff};
         end else if (bus_in.addr == OFS_FREEFALL) begin
            rd_data_ff <= {14'h0000, freefall_hysteresis_ff, ff_dur_ff,
                           freefall_threshold_ff};
         end else if (bus_in.addr == OFS_STATUS) begin
            rd_data_ff <= {25'h000_0000, code_ff,
                           flat_ff & ctrl_ff[CTRL_FLAT_EN],
                           ff_state_ff, flat_evt_ff, pos_evt_ff};
         end else begin
            rd_data_ff <= '0;
         end
      end else begin
         rd_data_ff <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // millisecond tick; the long count is a parameter for simulation
   logic [16:0] tick_cnt_ff;
   logic        ms_tick;
   assign ms_tick = (tick_cnt_ff == 17'(TICK_CYC - 1));

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         tick_cnt_ff <= '0;
      end else begin
         tick_cnt_ff <= ms_tick ? 17'h0_0000 : tick_cnt_ff + 17'h0_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sample arithmetic, shared by the tilt and flat comparisons
   logic [15:0] ax, ay, az;
   logic [10:0] sx, sy, sz;
   logic [22:0] r2;
   logic [21:0] z2;
   tffd_acc_t   prev_ff;

   assign ax = abs16(acc_in.x);
   assign ay = abs16(acc_in.y);
   assign az = abs16(acc_in.z);
   assign sx = sat1g(ax);
   assign sy = sat1g(ay);
   assign sz = sat1g(az);
   // squares instead of roots and arctangents
   assign r2 = 23'(sx) * 23'(sx) + 23'(sy) * 23'(sy);
   assign z2 = 22'(sz) * 22'(sz);

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         prev_ff <= '0;
      end else if (sample_valid_in) begin
         prev_ff <= acc_in;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // position blocking
   logic        tilt_blk;
   logic        over_1g5;
   logic [16:0] slope_max;
   logic        unstable;
   logic        blocked;
   logic [6:0]  stable_cnt_ff;

   // tan^2 < field/64  <=>  64 (x^2+y^2) < field z^2
   assign tilt_blk = ({11'h000, r2, 6'h00} <
                      40'(block_ang_ff) * 40'(z2));
   assign over_1g5 = (ax > ACC_1G5) || (ay > ACC_1G5) || (az > ACC_1G5);
   assign unstable = (stable_cnt_ff < STABLE_MS);

   always_comb begin
      slope_max = dabs(acc_in.x, prev_ff.x);
      if (dabs(acc_in.y, prev_ff.y) > slope_max) begin
         slope_max = dabs(acc_in.y, prev_ff.y);
      end
      if (dabs(acc_in.z, prev_ff.z) > slope_max) begin
         slope_max = dabs(acc_in.z, prev_ff.z);
      end
   end

   always_comb begin
      case (ctrl_ff[CTRL_BLOCK_LO +: 2])
         2'b00: blocked = 1'b0;
         2'b01: blocked = tilt_blk || over_1g5;
         2'b10: blocked = tilt_blk || (slope_max > SLOPE_LOW) ||
                          over_1g5;
         default: blocked = tilt_blk || (slope_max > SLOPE_HIGH) ||
                            (over_1g5 && unstable);
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // position code
   logic [2:0] nxt_code;
   logic [2:0] code_diff;
   logic       pos_change;

   always_comb begin
      if (ay < ax) begin
         nxt_code[1:0] = acc_in.x[15] ? 2'b01 : 2'b00;
      end else begin
         nxt_code[1:0] = acc_in.y[15] ? 2'b10 : 2'b11;
      end
      // noise around z = 0 must not toggle the face bit
      nxt_code[2] = (az > Z_HYST) ? acc_in.z[15] : code_ff[2];
   end

   assign code_diff  = nxt_code ^ code_ff;
   assign pos_change = sample_valid_in && !blocked &&
                       ((|code_diff[1:0]) ||
                        (code_diff[2] && ctrl_ff[CTRL_UPDOWN]));

   // blocked samples freeze the code as well as its event
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         code_ff <= '0;
      end else if (sample_valid_in && !blocked) begin
         code_ff <= nxt_code;
      end
   end

   // time since the code last changed, saturating at 100 ms
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         stable_cnt_ff <= '0;
      end else if (sample_valid_in && !blocked && (|code_diff)) begin
         stable_cnt_ff <= '0;
      end else if (ms_tick && unstable) begin
         stable_cnt_ff <= stable_cnt_ff + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flat state with hysteresis, scaled by 1024 to stay integer
   logic signed [17:0] set_lvl;
   logic [16:0]        set_pos;
   logic [16:0]        clr_lvl;
   logic [39:0]        lhs;
   logic               nxt_flat;

   assign set_lvl = 18'(flat_ang_ff) *
                    18'(FLAT_HYS_DEN - int'(level_hysteresis_ff)) -
                    18'(FLAT_HYS_OFS) * 18'(level_hysteresis_ff);
   // a negative lower level can never be undercut
   assign set_pos = set_lvl[17] ? 17'h0_0000 : set_lvl[16:0];
   assign clr_lvl = 17'(flat_ang_ff) *
                    17'(FLAT_HYS_DEN + int'(level_hysteresis_ff)) +
                    17'(FLAT_HYS_OFS) * 17'(level_hysteresis_ff);
   assign lhs     = {1'b0, r2, 16'h0000};

   always_comb begin
      if (flat_ff) begin
         nxt_flat = !(lhs > 40'(z2) * 40'(clr_lvl));
      end else begin
         nxt_flat = (lhs < 40'(z2) * 40'(set_pos));
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         flat_ff <= 1'b0;
      end else if (!ctrl_ff[CTRL_FLAT_EN]) begin
         flat_ff <= 1'b0;
      end else if (sample_valid_in) begin
         flat_ff <= nxt_flat;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flat hold time
   logic [11:0] hold_lim;
   logic [11:0] hold_cnt_ff;
   logic        hold_pend_ff;
   logic        flat_fire;
   logic        flat_chg;

   always_comb begin
      case (hold_sel_ff)
         2'b00: hold_lim = '0;
         2'b01: hold_lim = HOLD_MS_1;
         2'b10: hold_lim = HOLD_MS_2;
         default: hold_lim = HOLD_MS_3;
      endcase
   end

   assign flat_chg  = ctrl_ff[CTRL_FLAT_EN] && sample_valid_in &&
                      (nxt_flat != flat_ff);
   assign flat_fire = hold_pend_ff && !flat_chg &&
                      (hold_cnt_ff >= hold_lim);

   // a further change before the hold ends restarts the wait
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         hold_cnt_ff  <= '0;
         hold_pend_ff <= 1'b0;
      end else if (!ctrl_ff[CTRL_FLAT_EN]) begin
         hold_cnt_ff  <= '0;
         hold_pend_ff <= 1'b0;
      end else if (flat_chg) begin
         hold_cnt_ff  <= '0;
         hold_pend_ff <= 1'b1;
      end else if (flat_fire) begin
         hold_pend_ff <= 1'b0;
      end else if (ms_tick && hold_pend_ff) begin
         hold_cnt_ff  <= hold_cnt_ff + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event flags; a new event wins over any clear
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pos_evt_ff <= 1'b0;
      end else if (pos_change && ctrl_ff[CTRL_POS_EN]) begin
         pos_evt_ff <= 1'b1;
      end else if (ctrl_ff[CTRL_LATCH] ? clr_pos : sample_valid_in) begin
         pos_evt_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         flat_evt_ff <= 1'b0;
      end else if (flat_fire) begin
         flat_evt_ff <= 1'b1;
      end else if (ctrl_ff[CTRL_LATCH] ? clr_flat : sample_valid_in) begin
         flat_evt_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // free-fall engine
   logic [10:0] ff_thr;
   logic [11:0] ff_clr;
   logic [17:0] acc_sum;
   logic [9:0]  ff_lim;
   logic        ff_low;
   logic        ff_high;
   logic        ff_low_ff;
   logic [9:0]  ff_cnt_ff;

   assign ff_thr  = 11'(freefall_threshold_ff) << FF_THR_SHIFT;
   assign ff_clr  = 12'(ff_thr) +
                    (12'(freefall_hysteresis_ff) << FF_HYS_SHIFT);
   assign acc_sum = 18'(ax) + 18'(ay) + 18'(az);
   assign ff_lim  = (10'(ff_dur_ff) + 10'h001) * FF_DUR_STEP;

   always_comb begin
      if (ctrl_ff[CTRL_FF_SUM]) begin
         ff_low  = acc_sum < 18'(ff_thr);
         ff_high = acc_sum > 18'(ff_clr);
      end else begin
         ff_low  = (ax < 16'(ff_thr)) && (ay < 16'(ff_thr)) &&
                   (az < 16'(ff_thr));
         ff_high = (ax > 16'(ff_clr)) || (ay > 16'(ff_clr)) ||
                   (az > 16'(ff_clr));
      end
   end

   // low time is counted in ms ticks between samples
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ff_low_ff <= 1'b0;
         ff_cnt_ff <= '0;
      end else if (!ctrl_ff[CTRL_FF_EN] || (sample_valid_in && !ff_low)) begin
         ff_low_ff <= 1'b0;
         ff_cnt_ff <= '0;
      end else if (sample_valid_in) begin
         ff_low_ff <= 1'b1;
      end else if (ms_tick && ff_low_ff && (ff_cnt_ff < ff_lim)) begin
         ff_cnt_ff <= ff_cnt_ff + 10'h001;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ff_state_ff <= 1'b0;
      end else if (!ctrl_ff[CTRL_FF_EN]) begin
         ff_state_ff <= 1'b0;
      end else if (sample_valid_in && ff_high) begin
         ff_state_ff <= 1'b0;
      end else if (ff_low_ff && (ff_cnt_ff >= ff_lim)) begin
         ff_state_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign rd_data_out        = rd_data_ff;
   assign position_code_out  = code_ff;
   assign flat_state_out     = flat_ff;
   assign freefall_state_out = ff_state_ff;
   assign position_event_out = pos_evt_ff;
   assign flat_event_out     = flat_evt_ff;

endmodule

/* File: common/tffd_pkg.sv */
/*
 * package of the tilt, flat and free-fall engines: register offsets,
 * field positions, reset values, acceleration scales and timing counts.
 * assumes acceleration arrives filtered, signed, 1 g = 1024 lsb.
 */
package tffd_pkg;

   ////////////////////////////////////////////////////////////////////
   // clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_MS       = 1;
   localparam int TICK_CYCLES   = TICK_MS * 1_000_000 / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////
   // register offsets (word index on the plain port)
   localparam logic [3:0] OFS_CTRL     = 4'h0;
   localparam logic [3:0] OFS_ANGLE    = 4'h1;
   localparam logic [3:0] OFS_FREEFALL = 4'h2;
   localparam logic [3:0] OFS_STATUS   = 4'h3;

   // control fields
   localparam int CTRL_POS_EN   = 0;
   localparam int CTRL_FLAT_EN  = 1;
   localparam int CTRL_FF_EN    = 2;
   localparam int CTRL_FF_SUM   = 3;
   localparam int CTRL_LATCH    = 4;
   localparam int CTRL_UPDOWN   = 5;
   localparam int CTRL_BLOCK_LO = 6;
   // angle fields
   localparam int ANG_BLOCK_LO  = 0;
   localparam int ANG_FLAT_LO   = 8;
   localparam int ANG_HYST_LO   = 16;
   localparam int ANG_HOLD_LO   = 20;
   // free-fall fields
   localparam int FF_THR_LO     = 0;
   localparam int FF_DUR_LO     = 8;
   localparam int FF_HYST_LO    = 16;
   // status fields
   localparam int ST_POS_EVT    = 0;
   localparam int ST_FLAT_EVT   = 1;
   localparam int ST_FF         = 2;
   localparam int ST_FLAT       = 3;
   localparam int ST_CODE_LO    = 4;

   // values after reset
   localparam logic [7:0]  RST_CTRL      = 8'h00;
   localparam logic [5:0]  RST_BLOCK_ANG = 6'h08;
   localparam logic [5:0]  RST_FLAT_ANG  = 6'h08;
   localparam logic [7:0]  RST_FF_THR    = 8'h30;
   localparam logic [7:0]  RST_FF_DUR    = 8'h09;

   ////////////////////////////////////////////////////////////////////
   // acceleration scales, 1 g = 1024 lsb
   localparam logic [15:0] ACC_1G       = 16'h0400;
   localparam logic [15:0] ACC_1G5      = 16'h0600;
   localparam logic [16:0] SLOPE_LOW    = 17'h0_00CD; // 0.2 g
   localparam logic [16:0] SLOPE_HIGH   = 17'h0_019A; // 0.4 g
   localparam logic [15:0] Z_HYST       = 16'h00CD;   // 0.2 g
   localparam int          FF_THR_SHIFT = 3;          // 7.81 mg a step
   localparam int          FF_HYS_SHIFT = 7;          // 125 mg a step
   localparam int          FLAT_HYS_DEN = 1024;
   localparam int          FLAT_HYS_OFS = 64;         // 1024 / 16

   // times in milliseconds
   localparam logic [6:0]  STABLE_MS    = 7'h64;      // 100 ms
   localparam logic [11:0] HOLD_MS_1    = 12'h200;
   localparam logic [11:0] HOLD_MS_2    = 12'h400;
   localparam logic [11:0] HOLD_MS_3    = 12'h800;
   localparam logic [9:0]  FF_DUR_STEP  = 10'h002;

   ////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } tffd_acc_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } tffd_bus_t;

endpackage

/* File: verif/tffd_core_props.sv */
/*
 * checker of the tilt, flat and free-fall engines at the core's ports.
 * assumes it is bound to tffd_core and shadows the settings it needs.
 */
module tffd_core_props
   import tffd_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
)(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // register port
   input  wire tffd_bus_t   bus_in,
   input  wire logic [31:0] rd_data_out,
   // samples
   input  wire logic        sample_valid_in,
   input  wire tffd_acc_t   acc_in,
   // engine state
   input  wire logic [2:0]  position_code_out,
   input  wire logic        flat_state_out,
   input  wire logic        freefall_state_out,
   input  wire logic        position_event_out,
   input  wire logic        flat_event_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0]  ctrl_ff;
   logic [7:0]  thr_ff;
   logic [1:0]  hyst_ff;
   logic [17:0] ax;
   logic [17:0] ay;
   logic [17:0] az;
   logic [17:0] lim;
   logic        over;

   function automatic logic [17:0] mag(input logic signed [15:0] v);
      return v[15] ? 18'(-32'(v)) : 18'(v);
   endfunction

   //////////////////////////////////////////////////////////////////////
   // shadow settings; the core gives no other view of them
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_ff <= RST_CTRL;
         thr_ff <= RST_FF_THR;
         hyst_ff <= 2'h0;
      end else if (bus_in.wr && bus_in.addr == OFS_CTRL) begin
         ctrl_ff <= bus_in.wdata[7:0];
      end else if (bus_in.wr && bus_in.addr == OFS_FREEFALL) begin
         thr_ff <= bus_in.wdata[7:0];
         hyst_ff <= bus_in.wdata[17:16];
      end
   end

   // release level of free fall, threshold plus hysteresis
   assign ax = mag(acc_in.x);
   assign ay = mag(acc_in.y);
   assign az = mag(acc_in.z);
   assign lim = {7'h0, thr_ff, 3'h0} + {9'h0, hyst_ff, 7'h0};
   assign over = ctrl_ff[CTRL_FF_SUM] ? (ax + ay + az > lim)
                                      : (ax > lim || ay > lim || az > lim);

   //////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   sequence ctrl_wr_s; bus_in.wr && bus_in.addr == OFS_CTRL; endsequence
   sequence ctrl_rd_s; bus_in.rd && bus_in.addr == OFS_CTRL; endsequence

   rd_idle_zero_a: assert property (!bus_in.rd |=> rd_data_out == '0)
      else $error("read data not zero outside a read");
   unmapped_rd_a: assert property (
      bus_in.rd && bus_in.addr > OFS_STATUS |=> rd_data_out == '0)
      else $error("unmapped read not zero");
   ctrl_readback_a: assert property (ctrl_wr_s ##1 ctrl_rd_s |=>
      rd_data_out[7:0] == $past(bus_in.wdata[7:0], 2))
      else $error("control readback differs");
   status_echo_a: assert property (
      bus_in.rd && bus_in.addr == OFS_STATUS |=> rd_data_out[6:0] ==
      {$past(position_code_out), $past(flat_state_out),
       $past(freefall_state_out), $past(flat_event_out),
       $past(position_event_out)})
      else $error("status word differs from engine state");
   code_hold_a: assert property (
      !sample_valid_in |=> $stable(position_code_out))
      else $error("position code moved without a sample");
   pos_evt_cause_a: assert property ($rose(position_event_out) |->
      $past(sample_valid_in) && position_code_out != $past(position_code_out))
      else $error("position event without a code change");
   pos_evt_drop_a: assert property ($fell(position_event_out) |->
      $past(sample_valid_in) || $past(bus_in.wr))
      else $error("position event dropped without cause");
   flat_evt_drop_a: assert property ($fell(flat_event_out) |->
      $past(sample_valid_in) || $past(bus_in.wr))
      else $error("flat event dropped without cause");
   flat_off_a: assert property (
      !ctrl_ff[CTRL_FLAT_EN] [*2] |-> !flat_state_out)
      else $error("flat state shown while disabled");
   ff_release_a: assert property (
      sample_valid_in && over |=> !freefall_state_out)
      else $error("free fall kept above release level");
endmodule

bind tffd_core tffd_core_props #(.TICK_CYC(TICK_CYC)) tffd_core_props_inst (
   .clock_in(clock_in), .rst_in(rst_in), .bus_in(bus_in),
   .rd_data_out(rd_data_out), .sample_valid_in(sample_valid_in),
   .acc_in(acc_in), .position_code_out(position_code_out),
   .flat_state_out(flat_state_out), .freefall_state_out(freefall_state_out),
   .position_event_out(position_event_out), .flat_event_out(flat_event_out));

/* File: verif/testbench.sv */
/*
 * self-checking bench of the tilt, flat and free-fall engines.
 * assumes the core runs alone with its ms tick cut to 10 cycles.
 */
module testbench
   import tffd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clock_in = 1'b0;
   logic        rst_in = 1'b1;
   tffd_bus_t   bus_in = '0;
   logic        sample_valid_in = 1'b0;
   tffd_acc_t   acc_in = '0;
   logic [31:0] rd_data_out;
   logic [2:0]  code;
   logic        flat, ff, pos_evt, flat_evt;
   int          errors = 0;
   int          total_checks = 0;
   int          i;

   // 100 MHz clock
   always #5 clock_in = ~clock_in;

   tffd_core #(.TICK_CYC(10)) tffd_core_inst (
      .clock_in(clock_in), .rst_in(rst_in), .bus_in(bus_in),
      .rd_data_out(rd_data_out), .sample_valid_in(sample_valid_in),
      .acc_in(acc_in), .position_code_out(code), .flat_state_out(flat),
      .freefall_state_out(ff), .position_event_out(pos_evt),
      .flat_event_out(flat_evt));

   //////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one-cycle strobes, as the register port expects
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_in);
      bus_in <= '{1'b1, 1'b0, a, d};
      @(posedge clock_in);
      bus_in.wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clock_in);
      bus_in <= '{1'b0, 1'b1, a, 32'h0000_0000};
      @(posedge clock_in);
      bus_in.rd <= 1'b0;
      #1 check("rd_data", rd_data_out, exp);
   endtask

   // write then read back with no gap, the tightest legal spacing
   task automatic wr_rd(input logic [3:0] a, input logic [31:0] d, exp);
      @(posedge clock_in);
      bus_in <= '{1'b1, 1'b0, a, d};
      @(posedge clock_in);
      bus_in <= '{1'b0, 1'b1, a, 32'h0000_0000};
      @(posedge clock_in);
      bus_in.rd <= 1'b0;
      #1 check("rd_data", rd_data_out, exp);
   endtask

   // one sample pulse; returns once its result has landed
   task automatic smp(input int x, y, z);
      @(posedge clock_in);
      sample_valid_in <= 1'b1;
      acc_in <= '{16'(x), 16'(y), 16'(z)};
      @(posedge clock_in);
      sample_valid_in <= 1'b0;
      #1;
   endtask

   task automatic pos(input int x, y, z, input logic [2:0] c, input logic e);
      smp(x, y, z);
      check("code", 32'(code), 32'(c));
      check("pos_evt", 32'(pos_evt), 32'(e));
   endtask

   task automatic fl(input int x, input logic e);
      smp(x, 0, 1024);
      check("flat", 32'(flat), 32'(e));
   endtask

   task automatic summarize();
      if (errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the roughly 7000 cycles the tests need
   initial begin
      #500_000;
      errors++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge clock_in);
      rst_in <= 1'b0;
      rd(OFS_CTRL, 32'h0000_0000);
      rd(OFS_ANGLE, 32'h0000_0808);
      rd(OFS_FREEFALL, 32'h0000_0930);
      rd(4'hF, 32'h0000_0000);
      // orientation codes, up-down ignored then enabled, no blocking
      wr(OFS_CTRL, 32'h0000_0001);
      pos(1024, 0, 300, 3'h0, 1'b0);
      pos(-1024, 0, 300, 3'h1, 1'b1);
      pos(-1024, 0, 300, 3'h1, 1'b0);
      pos(0, -1024, 300, 3'h2, 1'b1);
      pos(0, 1024, 300, 3'h3, 1'b1);
      pos(1024, 0, -100, 3'h0, 1'b1);
      pos(1024, 0, -300, 3'h4, 1'b0);
      wr(OFS_CTRL, 32'h0000_0021);
      pos(1024, 0, 100, 3'h4, 1'b0);
      pos(1024, 0, 300, 3'h0, 1'b1);
      // blocking selectors
      wr(OFS_CTRL, 32'h0000_0061);
      pos(-200, 0, 1000, 3'h0, 1'b0);
      pos(-1600, 0, 0, 3'h0, 1'b0);
      pos(-1024, 0, 100, 3'h1, 1'b1);
      wr(OFS_CTRL, 32'h0000_0021);
      pos(200, 0, 1000, 3'h0, 1'b1);
      wr(OFS_CTRL, 32'h0000_00A1);
      pos(-1024, 0, 0, 3'h0, 1'b0);
      pos(-1024, 0, 0, 3'h1, 1'b1);
      wr_rd(OFS_CTRL, 32'h0000_00E1, 32'h0000_00E1);
      pos(-1024, -1100, 0, 3'h1, 1'b0);
      pos(-1024, -1100, 0, 3'h2, 1'b1);
      pos(-1024, -800, 0, 3'h1, 1'b1);
      // over 1.5 g blocks only while the code is younger than 100 ms
      pos(-1400, -1100, 0, 3'h1, 1'b0);
      pos(-1540, -1400, 0, 3'h1, 1'b0);
      pos(-1540, -1600, 0, 3'h1, 1'b0);
      repeat (1100) @(posedge clock_in);
      pos(-1540, -1600, 0, 3'h2, 1'b1);
      // latched event held until cleared through status
      wr(OFS_CTRL, 32'h0000_0031);
      pos(1024, 0, 300, 3'h0, 1'b1);
      pos(1024, 0, 300, 3'h0, 1'b1);
      rd(OFS_STATUS, 32'h0000_0001);
      wr(OFS_STATUS, 32'h0000_0001);
      rd(OFS_STATUS, 32'h0000_0000);
      // flat with hysteresis 7: set below 7.51, clear above 8.49
      wr(OFS_CTRL, 32'h0000_0002);
      fl(0, 1'b1);
      @(posedge clock_in);
      #1 check("flat_evt", 32'(flat_evt), 32'h1);
      wr(OFS_ANGLE, 32'h0007_0808);
      fl(365, 1'b1);
      fl(400, 1'b0);
      fl(357, 1'b0);
      fl(300, 1'b1);
      wr(OFS_ANGLE, 32'h0017_0808);
      fl(1024, 1'b0);
      repeat (5000) @(posedge clock_in);
      #1 check("flat_evt", 32'(flat_evt), 32'h0);
      for (i = 0; i < 300 && flat_evt !== 1'b1; i++) @(posedge clock_in);
      #1 check("flat_evt", 32'(flat_evt), 32'h1);
      // free fall, single mode, 2 ms, release above 512
      wr(OFS_CTRL, 32'h0000_0004);
      wr(OFS_FREEFALL, 32'h0001_0030);
      smp(100, 100, 100);
      check("ff", 32'(ff), 32'h0);
      for (i = 0; i < 40 && ff !== 1'b1; i++) @(posedge clock_in);
      #1 check("ff", 32'(ff), 32'h1);
      rd(OFS_STATUS, 32'h0000_0034);
      smp(450, 100, 100);
      check("ff", 32'(ff), 32'h1);
      smp(600, 100, 100);
      check("ff", 32'(ff), 32'h0);
      // sum mode, 20 ms
      wr(OFS_CTRL, 32'h0000_000C);
      wr(OFS_FREEFALL, 32'h0001_0930);
      smp(150, 150, 150);
      repeat (300) @(posedge clock_in);
      #1 check("ff", 32'(ff), 32'h0);
      smp(100, 100, 100);
      repeat (180) @(posedge clock_in);
      #1 check("ff", 32'(ff), 32'h0);
      for (i = 0; i < 60 && ff !== 1'b1; i++) @(posedge clock_in);
      #1 check("ff", 32'(ff), 32'h1);
      summarize();
   end
endmodule
